// file: hdl/dmabo_top.sv
// bus ownership, device lines and limited-rate request logic of a dma controller
// Functional notes
// - request bus mastership before any system bus transfer.
// - host frees bus after address strobe ends; then drive grant acknowledge.
// - ownership indicator leads grant acknowledge and trails its release.
// - drop bus request one clock after grant acknowledge is asserted.
// - acknowledge selects the peripheral; also on device-address memory cycles except under auto request.
// - line level status bit always mirrors the peripheral control line.
// - falling edge held low two clocks sets transition flag; write one clears.
// - interrupt mode requests interrupt while transition flag is set.
// - starting-pulse mode drives line low four clocks on activation.
// - abort mode: falling edge ends channel with external abort code.
// - enable-clock and ready device types turn the line into an input.
// - done is open-drain, driven with acknowledge of the last transfer.
// - done per chain end, per block in continue, and on memory cycles except under auto request.
// - device done during acknowledge ends channel after the whole operand.
// - both asserting done ends channel without device termination flag.
// - transfer complete marks successful transfers, never exceptions.
// - request field picks external, auto or mixed; maximum rate always pending.
// - limited rate uses back-to-back sample intervals watching grant acknowledge.
// - limited requests allowed in first two to the burst-time-plus-four clocks.
// - too much non-processor use blocks limited requests next interval.
// - sample interval is two to the burst-plus-ratio-plus-five clocks.
// - grant acknowledge active counts as non-processor use of the bus.
// - general control holds burst time in 3:2, ratio in 1:0.
// - error register holds five-bit code, external and software abort codes.
`timescale 1ns/10ps
module dmabo_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // system bus arbitration
  input wire logic bus_grant_line_n,
  input wire logic address_strobe_line_n,
  input wire logic grant_acknowledge_line_in,
  output logic grant_acknowledge_line_out,
  output logic grant_acknowledge_line_oe_n,
  output logic bus_request_n,
  output logic own_n,
  // peripheral lines
  input wire logic [3:0] peripheral_control_line_in,
  output logic [3:0] peripheral_control_line_out,
  output logic [3:0] peripheral_control_line_oe_n,
  output logic [3:0] ack_n,
  input wire logic done_line_in,
  output logic done_line_out,
  output logic done_line_oe_n,
  output logic transfer_complete_line_n,
  // from the transfer sequencer
  input wire logic [3:0] seq_need,
  input wire logic seq_busy,
  input wire logic [1:0] seq_ch,
  input wire logic seq_ack_phase,
  input wire logic seq_dev_cycle,
  input wire logic seq_mem2mem,
  input wire logic seq_block_end,
  input wire logic seq_final_block,
  input wire logic seq_continue,
  input wire logic seq_operand_end,
  input wire logic seq_strobe_window,
  input wire logic seq_exception,
  // to the sequencer and neighbours
  output logic bus_owned,
  output logic [3:0] auto_request,
  output logic [3:0] pcl_level,
  output logic [3:0] pcl_irq,
  output logic [3:0] channel_active
);

  function automatic logic [11:0] pow2(input logic [3:0] e);
    pow2 = 12'h001 << e;
  endfunction : pow2

  function automatic logic func_ignored(input logic [1:0] device_type_field);
    func_ignored = (device_type_field == dmabo_pkg::DEVICE_TYPE_FIELD_ENABLE_CLK) || (device_type_field == dmabo_pkg::DEVICE_TYPE_FIELD_ACK_READY);
  endfunction : func_ignored

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [3:0][1:0] device_type_field_r;
  logic [3:0][2:0] func_r;
  logic [3:0][1:0] request_generation_field_r;
  logic [3:0] coc_r, coc_nxt, ndt_r, ndt_nxt, act_r, act_nxt, pct_r, pct_nxt;
  logic [3:0][4:0] code_r, code_nxt;
  logic [3:0] pcl_d1_r, pcl_d2_r;
  logic [3:0][2:0] pulse_r, pulse_nxt;
  logic [3:0] first_r, first_nxt;
  logic [3:0] devdone_r, devdone_nxt, owndone_r, owndone_nxt;
  logic [1:0] bt_r, br_r;
  logic [10:0] samp_r, samp_nxt, busy_r, busy_nxt;
  logic permit_r, permit_nxt;
  dmabo_pkg::dmabo_arb_t arb_r, arb_nxt;

  ////////////////////////////////////////////////////////////////////////
  // apb decode
  wire logic [1:0] a_ch = paddr[6:5];
  wire logic [2:0] a_idx = paddr[4:2];
  wire logic a_gcr = (paddr == dmabo_pkg::ADDR_GENERAL_CONTROL);
  wire logic a_chan = !paddr[7] && (paddr[1:0] == 2'h0) &&
                      (a_idx <= dmabo_pkg::IDX_CHANNEL_CONTROL);
  wire logic a_hit = a_gcr || a_chan;
  wire logic take = psel && penable && !pready;
  wire logic fire_wr = psel && penable && pready && pwrite && a_hit;
  wire logic wr_dcr = fire_wr && a_chan && (a_idx == dmabo_pkg::IDX_DEVICE_CONTROL);
  wire logic wr_ocr = fire_wr && a_chan && (a_idx == dmabo_pkg::IDX_OPERATION_CONTROL);
  wire logic wr_csr = fire_wr && a_chan && (a_idx == dmabo_pkg::IDX_CHANNEL_STATUS);
  wire logic wr_ccr = fire_wr && a_chan && (a_idx == dmabo_pkg::IDX_CHANNEL_CONTROL);
  wire logic wr_gcr = fire_wr && a_gcr;

  logic [7:0] csr_view;
  logic [31:0] rd_val;
  always_comb
  begin
    csr_view = 8'h00;
    csr_view[dmabo_pkg::CSR_COC] = coc_r[a_ch];
    csr_view[dmabo_pkg::CSR_NDT] = ndt_r[a_ch];
    csr_view[dmabo_pkg::CSR_ERR] = (code_r[a_ch] != dmabo_pkg::ERR_NONE);
    csr_view[dmabo_pkg::CSR_ACT] = act_r[a_ch];
    csr_view[dmabo_pkg::CSR_PCT] = pct_r[a_ch];
    csr_view[dmabo_pkg::CSR_PCS] = peripheral_control_line_in[a_ch];
    rd_val = 32'h0000_0000;
    if (a_gcr)
    begin
      rd_val[dmabo_pkg::GCR_BT_LSB +: 2] = bt_r;
      rd_val[dmabo_pkg::GCR_BR_LSB +: 2] = br_r;
    end
    else if (a_chan)
    begin
      case (a_idx)
        dmabo_pkg::IDX_DEVICE_CONTROL:
        begin
          rd_val[dmabo_pkg::DCR_TYPE_LSB +: 2] = device_type_field_r[a_ch];
          rd_val[dmabo_pkg::DCR_FUNC_LSB +: 3] = func_r[a_ch];
        end
        dmabo_pkg::IDX_OPERATION_CONTROL: rd_val[dmabo_pkg::OCR_REQUEST_GENERATION_FIELD_LSB +: 2] = request_generation_field_r[a_ch];
        dmabo_pkg::IDX_CHANNEL_STATUS: rd_val[7:0] = csr_view;
        dmabo_pkg::IDX_CHANNEL_ERROR: rd_val[4:0] = code_r[a_ch];
        default: rd_val = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // limited-rate sample intervals
  wire logic [11:0] samp_len = pow2(4'({2'h0, bt_r}) + 4'({2'h0, br_r}) +
                                    dmabo_pkg::SAMPLE_EXP_BASE);
  wire logic [11:0] win_len = pow2(4'({2'h0, bt_r}) + dmabo_pkg::BURST_EXP_BASE);
  wire logic [11:0] busy_limit = samp_len >> (4'({2'h0, br_r}) + dmabo_pkg::RATIO_EXP_BASE);
  wire logic samp_end = ({1'b0, samp_r} == (samp_len - 12'h001));
  wire logic bus_foreign = !grant_acknowledge_line_in;
  wire logic [11:0] busy_total = {1'b0, busy_r} + {11'h000, bus_foreign};
  wire logic limited_ok = permit_r && ({1'b0, samp_r} < win_len);

  always_comb
  begin
    samp_nxt = samp_end ? 11'h000 : samp_r + 11'h001;
    busy_nxt = samp_end ? 11'h000 : busy_total[10:0];
    permit_nxt = samp_end ? (busy_total <= busy_limit) : permit_r;
  end

  ////////////////////////////////////////////////////////////////////////
  // channel status, peripheral control line and done tracking
  logic [3:0] fall, auto_nxt, ack_nxt, irq_nxt, pcl_oe_nxt, need;
  logic done_drive_nxt;
  always_comb
  begin
    act_nxt = act_r;
    coc_nxt = coc_r;
    ndt_nxt = ndt_r;
    pct_nxt = pct_r;
    code_nxt = code_r;
    pulse_nxt = pulse_r;
    first_nxt = first_r;
    devdone_nxt = devdone_r;
    owndone_nxt = owndone_r;
    done_drive_nxt = 1'b0;
    for (int c = 0; c < dmabo_pkg::NUM_CH; c++)
    begin
      logic cur;
      logic ign;
      logic end_op;
      logic acked;
      cur = (seq_ch == 2'(c));
      ign = func_ignored(device_type_field_r[c]);
      end_op = seq_operand_end && cur;
      acked = seq_ack_phase && cur && !ack_n[c];
      fall[c] = pcl_d2_r[c] && !pcl_d1_r[c] && !peripheral_control_line_in[c];
      // software side first so hardware events below win
      if (wr_csr && (a_ch == 2'(c)))
      begin
        if (pwdata[dmabo_pkg::CSR_COC]) coc_nxt[c] = 1'b0;
        if (pwdata[dmabo_pkg::CSR_NDT]) ndt_nxt[c] = 1'b0;
        if (pwdata[dmabo_pkg::CSR_ERR]) code_nxt[c] = dmabo_pkg::ERR_NONE;
        if (pwdata[dmabo_pkg::CSR_PCT]) pct_nxt[c] = 1'b0;
      end
      if (fall[c]) pct_nxt[c] = 1'b1;
      if (wr_ccr && (a_ch == 2'(c)) && pwdata[dmabo_pkg::CCR_START] && !act_r[c])
      begin
        act_nxt[c] = 1'b1;
        first_nxt[c] = 1'b1;
        if (!ign && (func_r[c] == dmabo_pkg::PCL_START_PULSE))
          pulse_nxt[c] = dmabo_pkg::START_PULSE_CYCLES;
      end
      else if (pulse_r[c] != 3'h0)
        pulse_nxt[c] = pulse_r[c] - 3'h1;
      if (end_op) first_nxt[c] = 1'b0;
      // done seen while acknowledge is out; we drive it ourselves on the last transfer
      if (acked && seq_block_end && (seq_final_block || seq_continue))
        done_drive_nxt = 1'b1;
      if (acked && !done_line_in && done_line_oe_n) devdone_nxt[c] = 1'b1;
      if (acked && !done_line_oe_n) owndone_nxt[c] = 1'b1;
      // own drive seen this cycle counts too, it may start on the operand's last cycle
      if (act_r[c] && end_op && (devdone_r[c] || owndone_r[c]))
      begin
        act_nxt[c] = 1'b0;
        coc_nxt[c] = 1'b1;
        ndt_nxt[c] = devdone_r[c] && !owndone_nxt[c];
        devdone_nxt[c] = 1'b0;
        owndone_nxt[c] = 1'b0;
      end
      if (act_r[c] && !ign && (func_r[c] == dmabo_pkg::PCL_ABORT) && (pct_r[c] || fall[c]))
      begin
        act_nxt[c] = 1'b0;
        coc_nxt[c] = 1'b1;
        code_nxt[c] = dmabo_pkg::ERR_EXT_ABORT;
      end
      else if (wr_ccr && (a_ch == 2'(c)) && pwdata[dmabo_pkg::CCR_ABORT] && act_r[c])
      begin
        act_nxt[c] = 1'b0;
        coc_nxt[c] = 1'b1;
        code_nxt[c] = dmabo_pkg::ERR_SW_ABORT;
      end
      if (!act_nxt[c]) pulse_nxt[c] = 3'h0;
      case (request_generation_field_r[c])
        dmabo_pkg::REQUEST_GENERATION_FIELD_AUTO_MAX: auto_nxt[c] = act_nxt[c];
        dmabo_pkg::REQUEST_GENERATION_FIELD_AUTO_LIMITED: auto_nxt[c] = act_nxt[c] && limited_ok;
        dmabo_pkg::REQUEST_GENERATION_FIELD_MIXED: auto_nxt[c] = act_nxt[c] && first_nxt[c];
        default: auto_nxt[c] = 1'b0;
      endcase
      ack_nxt[c] = !(seq_ack_phase && cur && act_r[c] && seq_dev_cycle &&
                     !(seq_mem2mem && ((request_generation_field_r[c] == dmabo_pkg::REQUEST_GENERATION_FIELD_AUTO_MAX) ||
                       (request_generation_field_r[c] == dmabo_pkg::REQUEST_GENERATION_FIELD_AUTO_LIMITED))));
      irq_nxt[c] = !ign && (func_r[c] == dmabo_pkg::PCL_INTERRUPT) && pct_nxt[c];
      pcl_oe_nxt[c] = !(!ign && (pulse_nxt[c] != 3'h0));
      need[c] = act_r[c] && (seq_need[c] || auto_request[c]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus arbitration
  always_comb
  begin
    arb_nxt = arb_r;
    case (arb_r)
      dmabo_pkg::ARB_IDLE: if (|need) arb_nxt = dmabo_pkg::ARB_REQ;
      dmabo_pkg::ARB_REQ: if (!bus_grant_line_n) arb_nxt = dmabo_pkg::ARB_WAIT;
      dmabo_pkg::ARB_WAIT:
        if (address_strobe_line_n && grant_acknowledge_line_in)
          arb_nxt = dmabo_pkg::ARB_PRE;
      dmabo_pkg::ARB_PRE: arb_nxt = dmabo_pkg::ARB_OWN;
      dmabo_pkg::ARB_OWN: if (!seq_busy && !(|need)) arb_nxt = dmabo_pkg::ARB_POST;
      dmabo_pkg::ARB_POST: arb_nxt = dmabo_pkg::ARB_IDLE;
      default: arb_nxt = dmabo_pkg::ARB_IDLE;
    endcase
  end

  wire logic own_next = (arb_nxt == dmabo_pkg::ARB_PRE) || (arb_nxt == dmabo_pkg::ARB_OWN) ||
                        (arb_nxt == dmabo_pkg::ARB_POST);
  wire logic req_next = (arb_nxt == dmabo_pkg::ARB_REQ) || (arb_nxt == dmabo_pkg::ARB_WAIT) ||
                        (arb_nxt == dmabo_pkg::ARB_PRE) ||
                        ((arb_nxt == dmabo_pkg::ARB_OWN) && (arb_r != dmabo_pkg::ARB_OWN));
  wire logic dtc_next = seq_strobe_window && !seq_exception;

  ////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      device_type_field_r <= '0;
      func_r <= '0;
      request_generation_field_r <= {4{dmabo_pkg::OCR_RESET}};
      bt_r <= dmabo_pkg::GCR_RESET[3:2];
      br_r <= dmabo_pkg::GCR_RESET[1:0];
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= take;
      if (take)
      begin
        prdata <= rd_val;
        pslverr <= !a_hit;
      end
      if (wr_dcr)
      begin
        device_type_field_r[a_ch] <= pwdata[dmabo_pkg::DCR_TYPE_LSB +: 2];
        func_r[a_ch] <= pwdata[dmabo_pkg::DCR_FUNC_LSB +: 3];
      end
      if (wr_ocr) request_generation_field_r[a_ch] <= pwdata[dmabo_pkg::OCR_REQUEST_GENERATION_FIELD_LSB +: 2];
      if (wr_gcr)
      begin
        bt_r <= pwdata[dmabo_pkg::GCR_BT_LSB +: 2];
        br_r <= pwdata[dmabo_pkg::GCR_BR_LSB +: 2];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      act_r <= 4'h0;
      coc_r <= 4'h0;
      ndt_r <= 4'h0;
      pct_r <= 4'h0;
      code_r <= '0;
      pulse_r <= '0;
      first_r <= 4'h0;
      devdone_r <= 4'h0;
      owndone_r <= 4'h0;
      pcl_d1_r <= 4'hF;
      pcl_d2_r <= 4'hF;
      samp_r <= 11'h000;
      busy_r <= 11'h000;
      permit_r <= 1'b1;
      arb_r <= dmabo_pkg::ARB_IDLE;
    end
    else
    begin
      act_r <= act_nxt;
      coc_r <= coc_nxt;
      ndt_r <= ndt_nxt;
      pct_r <= pct_nxt;
      code_r <= code_nxt;
      pulse_r <= pulse_nxt;
      first_r <= first_nxt;
      devdone_r <= devdone_nxt;
      owndone_r <= owndone_nxt;
      pcl_d1_r <= peripheral_control_line_in;
      pcl_d2_r <= pcl_d1_r;
      samp_r <= samp_nxt;
      busy_r <= busy_nxt;
      permit_r <= permit_nxt;
      arb_r <= arb_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bus_request_n <= 1'b1;
      own_n <= 1'b1;
      grant_acknowledge_line_out <= 1'b0;
      grant_acknowledge_line_oe_n <= 1'b1;
      bus_owned <= 1'b0;
      ack_n <= 4'hF;
      done_line_out <= 1'b0;
      done_line_oe_n <= 1'b1;
      transfer_complete_line_n <= 1'b1;
      peripheral_control_line_out <= 4'h0;
      peripheral_control_line_oe_n <= 4'hF;
      auto_request <= 4'h0;
      pcl_level <= 4'hF;
      pcl_irq <= 4'h0;
      channel_active <= 4'h0;
    end
    else
    begin
      bus_request_n <= !req_next;
      own_n <= !own_next;
      grant_acknowledge_line_oe_n <= (arb_nxt != dmabo_pkg::ARB_OWN);
      bus_owned <= (arb_nxt == dmabo_pkg::ARB_OWN);
      ack_n <= ack_nxt;
      done_line_oe_n <= !done_drive_nxt;
      transfer_complete_line_n <= !dtc_next;
      peripheral_control_line_oe_n <= pcl_oe_nxt;
      auto_request <= auto_nxt;
      pcl_level <= peripheral_control_line_in;
      pcl_irq <= irq_nxt;
      channel_active <= act_nxt;
    end
  end

endmodule : dmabo_top

// file: hdl/dmabo_pkg.sv
// constants and types for the dma bus ownership and device line block
package dmabo_pkg;
  localparam int NUM_CH = 4;
  // register word indices inside a channel window, window stride 0x20
  localparam logic [2:0] IDX_DEVICE_CONTROL = 3'h0;
  localparam logic [2:0] IDX_OPERATION_CONTROL = 3'h1;
  localparam logic [2:0] IDX_CHANNEL_STATUS = 3'h2;
  localparam logic [2:0] IDX_CHANNEL_ERROR = 3'h3;
  localparam logic [2:0] IDX_CHANNEL_CONTROL = 3'h4;
  localparam logic [7:0] ADDR_GENERAL_CONTROL = 8'h80;
  // device control fields
  localparam int DCR_TYPE_LSB = 4;
  localparam int DCR_FUNC_LSB = 0;
  // operation control fields
  localparam int OCR_REQUEST_GENERATION_FIELD_LSB = 0;
  // channel status bits
  localparam int CSR_COC = 7;
  localparam int CSR_BTC = 6;
  localparam int CSR_NDT = 5;
  localparam int CSR_ERR = 4;
  localparam int CSR_ACT = 3;
  localparam int CSR_PCT = 1;
  localparam int CSR_PCS = 0;
  // channel control bits
  localparam int CCR_START = 7;
  localparam int CCR_ABORT = 4;
  // general control fields
  localparam int GCR_BT_LSB = 2;
  localparam int GCR_BR_LSB = 0;
  // reset values
  localparam logic [5:0] DCR_RESET = 6'h00;
  localparam logic [1:0] OCR_RESET = 2'h2;
  localparam logic [3:0] GCR_RESET = 4'h0;
  // error codes
  localparam logic [4:0] ERR_NONE = 5'h00;
  localparam logic [4:0] ERR_EXT_ABORT = 5'h10;
  localparam logic [4:0] ERR_SW_ABORT = 5'h11;
  // device types
  localparam logic [1:0] DEVICE_TYPE_FIELD_ASYNC = 2'h0;
  localparam logic [1:0] DEVICE_TYPE_FIELD_ENABLE_CLK = 2'h1;
  localparam logic [1:0] DEVICE_TYPE_FIELD_ACK = 2'h2;
  localparam logic [1:0] DEVICE_TYPE_FIELD_ACK_READY = 2'h3;
  // peripheral control line functions
  localparam logic [2:0] PCL_STATUS = 3'h0;
  localparam logic [2:0] PCL_INTERRUPT = 3'h1;
  localparam logic [2:0] PCL_START_PULSE = 3'h2;
  localparam logic [2:0] PCL_ABORT = 3'h3;
  // request generation
  localparam logic [1:0] REQUEST_GENERATION_FIELD_AUTO_LIMITED = 2'h0;
  localparam logic [1:0] REQUEST_GENERATION_FIELD_AUTO_MAX = 2'h1;
  localparam logic [1:0] REQUEST_GENERATION_FIELD_EXTERNAL = 2'h2;
  localparam logic [1:0] REQUEST_GENERATION_FIELD_MIXED = 2'h3;
  // timing
  localparam logic [2:0] START_PULSE_CYCLES = 3'h4;
  localparam logic [3:0] BURST_EXP_BASE = 4'h4;
  localparam logic [3:0] SAMPLE_EXP_BASE = 4'h5;
  localparam logic [3:0] RATIO_EXP_BASE = 4'h1;
  typedef enum logic [2:0] {
    ARB_IDLE, ARB_REQ, ARB_WAIT, ARB_PRE, ARB_OWN, ARB_POST
  } dmabo_arb_t;
endpackage : dmabo_pkg

// file: verification/dmabo_host_model.sv
// host processor model: bus grant, address strobe and the grant acknowledge wire
`timescale 1ns/10ps
module dmabo_host_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // arbitration lines
  input wire logic bus_request_n,
  input wire logic gack_oe_n,
  input wire logic grant_en,
  output logic bus_grant_line_n,
  output logic address_strobe_line_n,
  output logic gack_wire
);
  logic [1:0] cyc_r;
  // pulled-up wire, low only while the controller drives it
  assign gack_wire = gack_oe_n;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cyc_r <= 2'h0;
      bus_grant_line_n <= 1'b1;
      address_strobe_line_n <= 1'b1;
    end
    else
    begin
      cyc_r <= cyc_r + 2'h1;
      // strobes only while it owns the bus and has not granted it
      address_strobe_line_n <= !(gack_wire && bus_grant_line_n && cyc_r != 2'h3);
      // grant on request, withdrawn once acknowledge is seen
      bus_grant_line_n <= !(grant_en && !bus_request_n && gack_wire);
    end
endmodule : dmabo_host_model

// file: verification/dmabo_top_asserts.sv
// concurrent checks on the ownership and device line ports
`timescale 1ns/10ps
module dmabo_top_asserts (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // arbitration
  input wire logic bus_grant_line_n,
  input wire logic address_strobe_line_n,
  input wire logic grant_acknowledge_line_oe_n,
  input wire logic bus_request_n,
  input wire logic own_n,
  input wire logic bus_owned,
  // device lines
  input wire logic [3:0] peripheral_control_line_oe_n,
  input wire logic [3:0] ack_n,
  input wire logic done_line_oe_n,
  input wire logic transfer_complete_line_n,
  input wire logic seq_ack_phase,
  input wire logic seq_exception
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  req_before_own_a:
    assert property ($fell(own_n) |-> !bus_request_n) else $error("own without request");
  grant_before_own_a:
    assert property ($fell(own_n) |-> $past(!bus_grant_line_n && address_strobe_line_n))
    else $error("own before grant and idle strobe");
  owned_flag_a:
    assert property (!grant_acknowledge_line_oe_n |-> bus_owned && !own_n)
    else $error("grant ack without owned flag");
  own_lead_a:
    assert property ($fell(grant_acknowledge_line_oe_n) |-> $past(!own_n))
    else $error("own did not lead grant ack");
  own_trail_a:
    assert property ($rose(grant_acknowledge_line_oe_n) |-> !own_n ##1 own_n)
    else $error("own did not trail grant ack by one");
  req_drop_a:
    assert property ($fell(grant_acknowledge_line_oe_n) |-> !bus_request_n ##1 bus_request_n)
    else $error("request not dropped one clock after grant ack");
  ack_idle_a:
    assert property (!seq_ack_phase |=> &ack_n) else $error("ack outside ack phase");
  start_pulse_a:
    assert property ($fell(peripheral_control_line_oe_n[0]) |->
      (!peripheral_control_line_oe_n[0]) [*4] ##1 peripheral_control_line_oe_n[0])
    else $error("start pulse not four clocks");
  done_with_ack_a:
    assert property (!done_line_oe_n |-> !(&ack_n)) else $error("done without ack");
  dtc_exception_a:
    assert property (seq_exception |=> transfer_complete_line_n)
    else $error("transfer complete on exception");
endmodule : dmabo_top_asserts
bind dmabo_top dmabo_top_asserts chk_u (.pclk, .presetn, .bus_grant_line_n,
  .address_strobe_line_n, .grant_acknowledge_line_oe_n, .bus_request_n, .own_n, .bus_owned,
  .peripheral_control_line_oe_n, .ack_n, .done_line_oe_n, .transfer_complete_line_n,
  .seq_ack_phase, .seq_exception);

// file: verification/dmabo_top_bench.sv
// self-checking bench for the ownership and device line block
`timescale 1ns/10ps
module dmabo_top_bench;
  typedef struct packed {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e; logic er;} dmabo_row_t;
  localparam dmabo_row_t ROWS [11] = '{
    '{8'h00, 1'b0, 32'h0, 32'h00, 1'b0}, '{8'h04, 1'b0, 32'h0, 32'h02, 1'b0},
    '{8'h80, 1'b0, 32'h0, 32'h00, 1'b0}, '{8'h80, 1'b1, 32'hFF, 32'h0, 1'b0},
    '{8'h80, 1'b0, 32'h0, 32'h0F, 1'b0}, '{8'h80, 1'b1, 32'h00, 32'h0, 1'b0},
    '{8'h0C, 1'b0, 32'h0, 32'h00, 1'b0}, '{8'h90, 1'b0, 32'h0, 32'h00, 1'b1},
    '{8'h20, 1'b1, 32'h12, 32'h0, 1'b0}, '{8'h20, 1'b0, 32'h0, 32'h12, 1'b0},
    '{8'h48, 1'b0, 32'h0, 32'h01, 1'b0}};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, grant_en, rerr, dev_done_n;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic bus_grant_line_n, address_strobe_line_n, gack_wire, bus_request_n, own_n, bus_owned;
  logic grant_acknowledge_line_oe_n, done_line_oe_n, transfer_complete_line_n;
  logic [3:0] pcl_drv, peripheral_control_line_oe_n, ack_n, auto_request, pcl_irq, channel_active;
  logic [1:0] seq_ch;
  logic seq_ack_phase, seq_dev_cycle, seq_block_end, seq_operand_end, seq_strobe_window;
  logic seq_exception;
  int n_errors, tests_run, cnt;
  wire [3:0] pcl_wire = pcl_drv & peripheral_control_line_oe_n;
  wire done_wire = dev_done_n & done_line_oe_n;
  dmabo_top dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .bus_grant_line_n, .address_strobe_line_n, .grant_acknowledge_line_in(gack_wire),
    .grant_acknowledge_line_out(), .grant_acknowledge_line_oe_n, .bus_request_n, .own_n,
    .peripheral_control_line_in(pcl_wire), .peripheral_control_line_out(),
    .peripheral_control_line_oe_n, .ack_n, .done_line_in(done_wire), .done_line_out(),
    .done_line_oe_n, .transfer_complete_line_n, .seq_need(4'h0), .seq_busy(1'b0), .seq_ch,
    .seq_ack_phase, .seq_dev_cycle, .seq_mem2mem(1'b0), .seq_block_end,
    .seq_final_block(seq_block_end), .seq_continue(1'b0), .seq_operand_end, .seq_strobe_window,
    .seq_exception, .bus_owned, .auto_request, .pcl_level(), .pcl_irq, .channel_active);
  dmabo_host_model host_u (.pclk, .presetn, .bus_request_n, .gack_oe_n(grant_acknowledge_line_oe_n),
    .grant_en, .bus_grant_line_n, .address_strobe_line_n, .gack_wire);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (n_errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("Error %s expected %0h seen %0h", what, exp, got);
      n_errors++;
    end
  endtask : chk
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk("register read", e, rdat);
  endtask : rd
  task automatic wait_owned(input logic v);
    cnt = 0;
    while (bus_owned !== v && cnt < 200)
    begin
      cnt++;
      @(posedge pclk);
    end
    chk("bus owned", 32'(v), 32'(bus_owned));
  endtask : wait_owned
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    end_of_test();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, grant_en, paddr, pwdata, seq_ch} = '0;
    {seq_ack_phase, seq_dev_cycle, seq_block_end, seq_operand_end} = '0;
    {seq_strobe_window, seq_exception} = '0;
    {pcl_drv, dev_done_n} = 5'h1F;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (ROWS[i])
    begin
      apb(ROWS[i].a, ROWS[i].w, ROWS[i].d);
      if (!ROWS[i].w)
        chk("row read", ROWS[i].e, rdat);
      chk("row slverr", 32'(ROWS[i].er), 32'(rerr));
    end
    // transition flag: held fall sets it, write one clears, glitch ignored
    pcl_drv[2] <= 1'b0;
    repeat (3) @(posedge pclk);
    rd(8'h48, 32'h02);
    pcl_drv[2] <= 1'b1;
    apb(8'h48, 1'b1, 32'h02);
    rd(8'h48, 32'h01);
    pcl_drv[2] <= 1'b0;
    @(posedge pclk);
    pcl_drv[2] <= 1'b1;
    repeat (3) @(posedge pclk);
    rd(8'h48, 32'h01);
    apb(8'h40, 1'b1, 32'h01);
    chk("irq before fall", 32'h0, 32'(pcl_irq[2]));
    pcl_drv[2] <= 1'b0;
    repeat (5) @(posedge pclk);
    chk("irq after fall", 32'h1, 32'(pcl_irq[2]));
    // limited rate with bt=br=0: 16 permitted clocks of every 32
    apb(8'h24, 1'b1, 32'h00);
    apb(8'h30, 1'b1, 32'h80);
    cnt = 0;
    repeat (64)
    begin
      @(posedge pclk);
      cnt += int'(auto_request[1]);
    end
    chk("limited requests", 32'(2 * (2 ** 4)), 32'(cnt));
    apb(8'h30, 1'b1, 32'h10);
    // ch0: start pulse, maximum rate, full arbitration, software abort
    apb(8'h00, 1'b1, 32'h02);
    apb(8'h04, 1'b1, 32'h01);
    grant_en <= 1'b1;
    apb(8'h10, 1'b1, 32'h80);
    chk("max rate request", 32'h1, 32'(auto_request[0]));
    wait_owned(1'b1);
    repeat (2) @(posedge pclk);
    chk("request dropped", 32'h1, 32'(bus_request_n));
    apb(8'h10, 1'b1, 32'h10);
    wait_owned(1'b0);
    rd(8'h0C, 32'h11);
    // ch3 done termination: device alone, then both parties
    for (int v = 0; v < 2; v++)
    begin
      apb(8'h70, 1'b1, 32'h80);
      {seq_ch, seq_ack_phase, seq_dev_cycle, seq_block_end, dev_done_n} <= {4'hF, v[0], 1'b0};
      repeat (3) @(posedge pclk);
      chk("ack", 32'h0, 32'(ack_n[3]));
      chk("done drive", 32'(!v[0]), 32'(done_line_oe_n));
      seq_operand_end <= 1'b1;
      @(posedge pclk);
      {seq_operand_end, seq_ack_phase, seq_dev_cycle, seq_block_end, dev_done_n} <= 5'h01;
      repeat (2) @(posedge pclk);
      rd(8'h68, v ? 32'h81 : 32'hA1);
      apb(8'h68, 1'b1, 32'hA0);
    end
    {seq_strobe_window, seq_exception} <= 2'h3;
    repeat (2) @(posedge pclk);
    chk("dtc on exception", 32'h1, 32'(transfer_complete_line_n));
    {seq_strobe_window, seq_exception} <= 2'h2;
    repeat (2) @(posedge pclk);
    chk("dtc on transfer", 32'h0, 32'(transfer_complete_line_n));
    {seq_strobe_window, seq_exception} <= 2'h0;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("reset outputs", 32'h7, {29'h0, own_n, bus_request_n, done_line_oe_n});
    chk("reset active", 32'h0, 32'(channel_active));
    end_of_test();
  end
endmodule : dmabo_top_bench
